// ---- smm_muting.v ----
`include "smm_defines.vh"

module smm_muting #(
  parameter TICK_CYCLES = `SMM_TICK_US * `SMM_CLK_MHZ
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [5:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Field pins, asynchronous
  input wire first_sensor,
  input wire second_sensor,
  input wire third_sensor,
  input wire fourth_sensor,
  input wire guard_in,
  input wire enable_in,
  // Results
  output reg muted_out,
  output reg mute_active
);

  localparam ST_IDLE = 3'h0;
  localparam ST_READY = 3'h1;
  localparam ST_FIRST = 3'h2;
  localparam ST_MUTE = 3'h3;
  localparam ST_BLIND = 3'h4;

  function [15:0] clamp;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // Sensors reordered so bit 0 is the first met in travel
  function [3:0] travel;
    input [3:0] s;
    input rev;
    begin
      travel = rev ? {s[0], s[1], s[2], s[3]} : s;
    end
  endfunction

  wire [5:0] pins_s;
  smm_sync #(.W(6)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in({enable_in, guard_in, fourth_sensor, third_sensor, second_sensor, first_sensor}),
    .sync_out(pins_s)
  );
  wire [3:0] sens = pins_s[3:0];
  wire guard = pins_s[4];
  wire en = pins_s[5];

  reg [`SMM_CTRL_W-1:0] ctrl_q;
  reg [15:0] win_q, tout_q, blind_q, eot_q;
  reg [31:0] pre_q;
  reg tick_q;
  reg [2:0] st_q, st_d;
  reg [15:0] tmr_q, tmr_d, cyc_q, cyc_d;
  reg [1:0] step_q, step_d;
  reg rev_q, rev_d, seen3_q, seen3_d, rel_q, rel_d;
  reg arm_q, arm_d, en_prev_q, guard_prev_q;

  wire [1:0] mode = ctrl_q[`SMM_F_MODE];
  wire [1:0] enmode = ctrl_q[`SMM_F_ENMODE];
  wire [1:0] dir = ctrl_q[`SMM_F_DIR];
  wire is_l = (mode == `SMM_MODE_L);
  wire is_seq = (mode == `SMM_MODE_SEQ);
  wire en_rise = en & ~en_prev_q;
  wire en_fall = ~en & en_prev_q;
  wire guard_rise = guard & ~guard_prev_q;
  wire [3:0] t = travel(sens, rev_q);
  wire [3:0] t_fwd = travel(sens, 1'b0);
  wire [3:0] t_rev = travel(sens, 1'b1);
  wire [3:0] ahead = (t >> step_q) >> 1;
  wire in_cycle = (st_q == ST_FIRST) || (st_q == ST_MUTE);

  // Opening free: relevant sensors clear and guard high
  wire free = guard && (is_l ? (sens[1:0] == 2'h0) : (sens == 4'h0));
  wire enabled = (enmode == `SMM_EN_NONE) || arm_q;
  wire fwd_ok = (dir != `SMM_DIR_DOWN);
  wire rev_ok = (dir != `SMM_DIR_UP) && !is_l;
  wire fwd_go = is_seq ? (t_fwd == 4'h1) : ((t_fwd[1:0] != 2'h0) && (t_fwd[3:2] == 2'h0));
  wire rev_go = is_seq ? (t_rev == 4'h1) : ((t_rev[1:0] != 2'h0) && (t_rev[3:2] == 2'h0));
  wire early = ctrl_q[`SMM_B_MINT] && (tmr_q < `SMM_MINT_TICKS);
  wire late = (tmr_q > win_q);
  wire tout_hit = (tout_q != 16'h0000) && (cyc_q >= tout_q);
  wire blind_use = ctrl_q[`SMM_B_BLIND] && (is_l || !ctrl_q[`SMM_B_CLOSE]);
  wire kill = (enmode == `SMM_EN_DIS) && en_fall;

  // Tick prescaler
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (pre_q >= TICK_CYCLES - 1) begin
      pre_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      pre_q <= pre_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // Sequencer
  always @* begin
    st_d = st_q;
    tmr_d = tick_q ? tmr_q + 16'h0001 : tmr_q;
    cyc_d = (in_cycle && tick_q) ? cyc_q + 16'h0001 : cyc_q;
    step_d = step_q;
    rev_d = rev_q;
    seen3_d = seen3_q;
    rel_d = rel_q;
    arm_d = arm_q;
    if (enmode == `SMM_EN_DIS && en_fall)
      arm_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        tmr_d = 16'h0000;
        cyc_d = 16'h0000;
        if (free)
          st_d = ST_READY;
      end
      ST_READY: begin
        tmr_d = 16'h0000;
        cyc_d = 16'h0000;
        step_d = 2'h1;
        seen3_d = 1'b0;
        rel_d = 1'b0;
        if (!guard) begin
          st_d = ST_IDLE;
        end else if (!free) begin
          st_d = ST_IDLE;
          if (enabled && fwd_ok && fwd_go) begin
            st_d = ST_FIRST;
            rev_d = 1'b0;
            arm_d = 1'b0;
          end else if (enabled && rev_ok && rev_go) begin
            st_d = ST_FIRST;
            rev_d = 1'b1;
            arm_d = 1'b0;
          end
        end
      end
      ST_FIRST: begin
        if (kill || tout_hit) begin
          st_d = ST_IDLE;
        end else if (is_seq) begin
          if (ahead != 4'h0) begin
            st_d = ST_IDLE;
          end else if (t[step_q]) begin
            if (step_q == 2'h1 && early)
              st_d = ST_IDLE;
            else if (step_q == 2'h3) begin
              st_d = ST_MUTE;
              tmr_d = 16'h0000;
            end else
              step_d = step_q + 2'h1;
          end
        end else begin
          if (!is_l && t[3:2] != 2'h0)
            st_d = ST_IDLE;
          else if (t[1:0] == 2'h3) begin
            if (early || late) begin
              st_d = ST_IDLE;
            end else begin
              st_d = ST_MUTE;
              tmr_d = 16'h0000;
            end
          end else if (t[1:0] == 2'h0 || late)
            st_d = ST_IDLE;
        end
      end
      ST_MUTE: begin
        if (t[2])
          seen3_d = 1'b1;
        if (is_l && !t[0] && !rel_q) begin
          rel_d = 1'b1;
          tmr_d = 16'h0000;
        end else if (!rel_q) begin
          tmr_d = 16'h0000;
        end
        if (kill || tout_hit) begin
          st_d = ST_IDLE;
        end else if ((is_l && rel_q && tmr_q >= eot_q)
            || ((is_l || !ctrl_q[`SMM_B_CLOSE]) && guard_rise)
            || (!is_l && ctrl_q[`SMM_B_CLOSE] && seen3_q && !t[2])) begin
          st_d = blind_use ? ST_BLIND : ST_IDLE;
          tmr_d = 16'h0000;
        end
      end
      ST_BLIND: begin
        if (kill || tmr_q >= blind_q)
          st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    if (enmode != `SMM_EN_NONE && en_rise)
      arm_d = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      tmr_q <= 16'h0000;
      cyc_q <= 16'h0000;
      step_q <= 2'h0;
      rev_q <= 1'b0;
      seen3_q <= 1'b0;
      rel_q <= 1'b0;
      arm_q <= 1'b0;
      en_prev_q <= 1'b0;
      guard_prev_q <= 1'b0;
      muted_out <= 1'b0;
      mute_active <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      cyc_q <= cyc_d;
      step_q <= step_d;
      rev_q <= rev_d;
      seen3_q <= seen3_d;
      rel_q <= rel_d;
      arm_q <= arm_d;
      en_prev_q <= en;
      guard_prev_q <= guard;
      muted_out <= (st_d == ST_MUTE) || (st_d == ST_BLIND) || guard;
      mute_active <= (st_d == ST_MUTE);
    end
  end

  // APB slave: one wait state, write commits at the completing edge
  wire acc = psel && penable;
  reg [31:0] rd;
  reg hit;
  always @* begin
    rd = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `SMM_ADDR_CTRL: rd[`SMM_CTRL_W-1:0] = ctrl_q;
      `SMM_ADDR_WIN: rd[15:0] = win_q;
      `SMM_ADDR_TOUT: rd[15:0] = tout_q;
      `SMM_ADDR_BLIND: rd[15:0] = blind_q;
      `SMM_ADDR_EOT: rd[15:0] = eot_q;
      `SMM_ADDR_STAT: rd[11:0] = {pins_s, arm_q, rev_q, muted_out, st_q};
      default: hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl_q <= `SMM_CTRL_RST;
      win_q <= `SMM_WIN_MIN;
      tout_q <= `SMM_TOUT_RST;
      blind_q <= `SMM_BLIND_MIN;
      eot_q <= `SMM_EOT_MIN;
    end else begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && !hit;
      prdata <= (acc && !pready && !pwrite) ? rd : 32'h0000_0000;
      if (acc && pready && pwrite) begin
        case (paddr)
          `SMM_ADDR_CTRL: ctrl_q <= pwdata[`SMM_CTRL_W-1:0];
          `SMM_ADDR_WIN: win_q <= clamp(pwdata[15:0], `SMM_WIN_MIN, `SMM_WIN_MAX);
          `SMM_ADDR_TOUT: tout_q <= (pwdata[15:0] == 16'h0000) ? 16'h0000 :
            clamp(pwdata[15:0], `SMM_TOUT_MIN, 16'hffff);
          `SMM_ADDR_BLIND: blind_q <= clamp(pwdata[15:0], `SMM_BLIND_MIN, `SMM_BLIND_MAX);
          `SMM_ADDR_EOT: eot_q <= clamp(pwdata[15:0], `SMM_EOT_MIN, `SMM_EOT_MAX);
          default: ;
        endcase
      end
    end
  end

endmodule // smm_muting

// ---- smm_defines.vh ----
// Operation
// - Concurrent start needs both of first pair occupied within the sensor window.
// - Four-sensor modes start only when all sensors clear and guard input high.
// - Muting stops at once when the cycle exceeds its timeout; zero is unlimited.
// - Enable/disable mode arms a cycle only on a rising enable edge.
// - Enable/disable mode ends muting on any falling enable edge.
// - Enable-only mode never ends muting; enable must fall before rearming.
// - Without enable option, muting is always enabled.
// - Direction setting limits travel to both, up only or down only.
// - Curtain close ends on guard rise; sensor close when third sensor clears.
// - Muted output is 1 while muting, else follows guard input.
// - Blind time holds guard as 1 after close; concurrent only with curtain close.
// - Minimum sensor time demands 150 ms between first two activations.
// - L mode uses two sensors and ends once the opening is released.
// - L mode starts only with both sensors clear and guard input high.
// - L mode ends muting when end-of-muting time from first release expires.
// - Sequential mode needs sensors in strict travel order, no sensor window limit.
`ifndef SMM_DEFINES_VH
`define SMM_DEFINES_VH

// Evaluation tick period and clock rate
`define SMM_TICK_US 10000
`define SMM_CLK_MHZ 100

// Register byte offsets
`define SMM_ADDR_CTRL 6'h00
`define SMM_ADDR_WIN 6'h04
`define SMM_ADDR_TOUT 6'h08
`define SMM_ADDR_BLIND 6'h0c
`define SMM_ADDR_EOT 6'h10
`define SMM_ADDR_STAT 6'h14

// Control fields
`define SMM_F_MODE 1:0
`define SMM_F_ENMODE 3:2
`define SMM_F_DIR 5:4
`define SMM_B_CLOSE 6
`define SMM_B_BLIND 7
`define SMM_B_MINT 8
`define SMM_CTRL_W 9

`define SMM_MODE_CONC 2'h0
`define SMM_MODE_L 2'h1
`define SMM_MODE_SEQ 2'h2
`define SMM_EN_NONE 2'h0
`define SMM_EN_DIS 2'h1
`define SMM_EN_ONLY 2'h2
`define SMM_DIR_BOTH 2'h0
`define SMM_DIR_UP 2'h1
`define SMM_DIR_DOWN 2'h2

// Limits and resets, in ticks of 10 ms
`define SMM_WIN_MIN 16'h00c8
`define SMM_WIN_MAX 16'h01f4
`define SMM_TOUT_MIN 16'h03e8
`define SMM_TOUT_RST 16'h03e8
`define SMM_BLIND_MIN 16'h0019
`define SMM_BLIND_MAX 16'h0064
`define SMM_EOT_MIN 16'h00fa
`define SMM_EOT_MAX 16'h0258
`define SMM_MINT_TICKS 16'h000f
`define SMM_CTRL_RST 9'h000

`endif

// ---- smm_sync.v ----
module smm_sync #(
  parameter W = 6
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Asynchronous levels and their synchronised copies
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] meta_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // smm_sync

// ---- smm_muting_monitor.sv ----
module smm_muting_monitor (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Field and result
  input wire second_sensor,
  input wire third_sensor,
  input wire guard_in,
  input wire muted_out,
  input wire mute_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_hold; mute_active |-> muted_out; endproperty
  a_hold: assert property (p_hold) else $error("muted low while muting");
  property p_free; guard_in [*6] |-> muted_out; endproperty
  a_free: assert property (p_free) else $error("muted low with free guard");
  property p_fall; $fell(muted_out) |-> !($past(guard_in, 3) && $past(guard_in, 4)); endproperty
  a_fall: assert property (p_fall) else $error("muted fell with guard high");
  property p_pair; $rose(mute_active) |-> $past(second_sensor, 3) || $past(third_sensor, 3);
  endproperty
  a_pair: assert property (p_pair) else $error("muting without sensors");
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no ready after wait state");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than a cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_zero; !pready || (pslverr && !pwrite) |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("read data not zero");
  c_mute: cover property ($rose(mute_active));
  c_stop: cover property ($fell(mute_active));
  c_err: cover property (pslverr);
endmodule // smm_muting_monitor

bind smm_muting smm_muting_monitor smm_muting_monitor_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .second_sensor(second_sensor), .third_sensor(third_sensor),
  .guard_in(guard_in), .muted_out(muted_out), .mute_active(mute_active));

// ---- smm_field_model.sv ----
module smm_field_model (
  // Clock
  input wire pclk,
  // Scene: occupied sensors, curtain interrupted
  input wire [3:0] occ,
  input wire blocked,
  // Pins
  output logic first_sensor,
  output logic second_sensor,
  output logic third_sensor,
  output logic fourth_sensor,
  output logic guard_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial guard_in = 1'b1;
  initial {fourth_sensor, third_sensor, second_sensor, first_sensor} = 4'h0;
  always @(posedge pclk) begin
    {fourth_sensor, third_sensor, second_sensor, first_sensor} <= occ;
    guard_in <= !blocked;
  end
endmodule // smm_field_model

// ---- test_smm_muting.sv ----
`include "smm_defines.vh"

module test_smm_muting;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [5:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h0;
  logic enable_in = 1'b0;
  logic [3:0] occ = 4'h0;
  logic blocked = 1'b0;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int checks = 0;
  wire [31:0] prdata;
  wire pready, pslverr, muted_out, mute_active, guard_in;
  wire first_sensor, second_sensor, third_sensor, fourth_sensor;
  always #5 pclk = ~pclk;
  smm_muting #(.TICK_CYCLES(10)) smm_muting_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_sensor(first_sensor),
    .second_sensor(second_sensor), .third_sensor(third_sensor), .fourth_sensor(fourth_sensor),
    .guard_in(guard_in), .enable_in(enable_in), .muted_out(muted_out),
    .mute_active(mute_active));
  smm_field_model smm_field_model_i (.pclk(pclk), .occ(occ), .blocked(blocked),
    .first_sensor(first_sensor), .second_sensor(second_sensor), .third_sensor(third_sensor),
    .fourth_sensor(fourth_sensor), .guard_in(guard_in));
  task automatic tally_and_finish();
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      check(pready, 1'b1);
      tally_and_finish();
    end
  endtask
  task automatic scene(input logic [3:0] o, input logic b, input int n);
    occ <= o;
    blocked <= b;
    idle(n);
  endtask
  task automatic wait_mute(input logic exp, input int n);
    while (mute_active !== exp && n > 0) begin
      @(posedge pclk);
      n--;
    end
    check(mute_active, exp);
    if (mute_active !== exp) tally_and_finish();
  endtask
  task automatic go();
    scene(4'b0001, 1'b0, 20);
    scene(4'b0011, 1'b0, 20);
    wait_mute(1'b1, 10);
  endtask
  task automatic close();
    scene(4'b1111, 1'b1, 20);
    scene(4'b0000, 1'b0, 0);
    wait_mute(1'b0, 20);
  endtask
  task automatic s_regs();
    logic [5:0] a[5] = '{`SMM_ADDR_CTRL, `SMM_ADDR_WIN, `SMM_ADDR_TOUT, `SMM_ADDR_BLIND,
      `SMM_ADDR_EOT};
    logic [31:0] e[5] = '{32'h0, 32'hc8, 32'h3e8, 32'h19, 32'hfa};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, a[i], 32'h0);
      check(rd, e[i]);
    end
    apb(1'b1, `SMM_ADDR_WIN, 32'h1);
    apb(1'b0, `SMM_ADDR_WIN, 32'h0);
    check(rd, 32'hc8);
    apb(1'b0, 6'h18, 32'h0);
    check(err, 1'b1);
    // Opening free after reset: ready state, muted high, guard pin seen high
    apb(1'b0, `SMM_ADDR_STAT, 32'h0);
    check(rd, 32'h409);
    check(err, 1'b0);
  endtask
  task automatic s_conc();
    go();
    scene(4'b1111, 1'b1, 20);
    check(muted_out, 1'b1);
    scene(4'b1100, 1'b1, 20);
    check(mute_active, 1'b1);
    scene(4'b0000, 1'b0, 0);
    wait_mute(1'b0, 20);
    scene(4'b0000, 1'b1, 20);
    check(muted_out, 1'b0);
    scene(4'b0000, 1'b0, 20);
  endtask
  task automatic s_window_dir();
    scene(4'b0001, 1'b0, 2200);
    scene(4'b0011, 1'b0, 20);
    check(mute_active, 1'b0);
    scene(4'b0000, 1'b0, 20);
    apb(1'b1, `SMM_ADDR_CTRL, 32'h10);
    scene(4'b1000, 1'b0, 20);
    scene(4'b1100, 1'b0, 20);
    check(mute_active, 1'b0);
    scene(4'b0000, 1'b0, 20);
    apb(1'b1, `SMM_ADDR_CTRL, 32'h0);
    scene(4'b1000, 1'b0, 20);
    scene(4'b1100, 1'b0, 20);
    check(mute_active, 1'b1);
    close();
    apb(1'b1, `SMM_ADDR_CTRL, 32'h20);
    scene(4'b0001, 1'b0, 20);
    scene(4'b0011, 1'b0, 20);
    check(mute_active, 1'b0);
    scene(4'b0000, 1'b0, 20);
    // Sensor close: third sensor clears while the curtain is still interrupted
    apb(1'b1, `SMM_ADDR_CTRL, 32'h40);
    go();
    scene(4'b1111, 1'b1, 20);
    check(mute_active, 1'b1);
    scene(4'b1011, 1'b1, 0);
    wait_mute(1'b0, 20);
    check(muted_out, 1'b0);
    scene(4'b0000, 1'b0, 20);
  endtask
  task automatic s_enable();
    apb(1'b1, `SMM_ADDR_CTRL, 32'h4);
    scene(4'b0001, 1'b0, 20);
    scene(4'b0011, 1'b0, 20);
    check(mute_active, 1'b0);
    scene(4'b0000, 1'b0, 20);
    enable_in <= 1'b1;
    go();
    enable_in <= 1'b0;
    wait_mute(1'b0, 20);
    scene(4'b0000, 1'b0, 20);
    apb(1'b1, `SMM_ADDR_CTRL, 32'h8);
    enable_in <= 1'b1;
    go();
    enable_in <= 1'b0;
    idle(20);
    check(mute_active, 1'b1);
    close();
  endtask
  task automatic s_timers();
    apb(1'b1, `SMM_ADDR_CTRL, 32'h0);
    go();
    idle(9700);
    check(mute_active, 1'b1);
    wait_mute(1'b0, 400);
    scene(4'b0000, 1'b0, 20);
    apb(1'b1, `SMM_ADDR_CTRL, 32'h80);
    go();
    close();
    scene(4'b0000, 1'b1, 100);
    check(muted_out, 1'b1);
    idle(300);
    check(muted_out, 1'b0);
    scene(4'b0000, 1'b0, 20);
  endtask
  task automatic s_modes();
    apb(1'b1, `SMM_ADDR_CTRL, 32'h100);
    scene(4'b0011, 1'b0, 20);
    check(mute_active, 1'b0);
    scene(4'b0000, 1'b0, 20);
    scene(4'b0001, 1'b0, 200);
    scene(4'b0011, 1'b0, 0);
    wait_mute(1'b1, 20);
    close();
    apb(1'b1, `SMM_ADDR_CTRL, 32'h2);
    scene(4'b0001, 1'b0, 20);
    scene(4'b0011, 1'b0, 20);
    scene(4'b0111, 1'b0, 20);
    check(mute_active, 1'b0);
    scene(4'b1111, 1'b0, 0);
    wait_mute(1'b1, 20);
    close();
    apb(1'b1, `SMM_ADDR_CTRL, 32'h1);
    go();
    scene(4'b0010, 1'b1, 2400);
    check(mute_active, 1'b1);
    wait_mute(1'b0, 300);
    scene(4'b0000, 1'b0, 20);
  endtask
  initial begin
    idle(10);
    presetn <= 1'b1;
    idle(5);
    s_regs();
    s_conc();
    s_window_dir();
    s_enable();
    s_timers();
    s_modes();
    tally_and_finish();
  end
endmodule // test_smm_muting
